/* File: design/esd_defs.vh */
`ifndef ESD_DEFS_VH
`define ESD_DEFS_VH

// ************************************************************
// Register map
// ************************************************************
`define ESD_ADDR_W 4
`define ESD_REG_ENABLE 4'h0
`define ESD_REG_TIME_C 4'h1
`define ESD_REG_TIME_D 4'h2
`define ESD_REG_TOL 4'h3
`define ESD_REG_STATUS 4'h4
`define ESD_REG_TEST 4'h5
`define ESD_REG_PENDING 4'h6

// ************************************************************
// Field positions and reset values
// ************************************************************
`define ESD_EN_BASE_BIT 0
`define ESD_EN_E_BIT 4
`define ESD_EN_EXT_BIT 6
`define ESD_EN_ESR_CFG_BIT 8
`define ESD_EN_ESR_OK_BIT 9
`define ESD_TEST_SEL_BIT 0
`define ESD_TEST_ACK_BIT 1
`define ESD_ENABLE_RST 16'h0000
`define ESD_TIME_RST 16'h0064
`define ESD_TOL_RST 16'h000a

// ************************************************************
// Timing
// ************************************************************
`define ESD_CLK_HZ 20000000
`define ESD_TICK_US 1000
`define ESD_TICK_CYC ((`ESD_CLK_HZ / 1000000) * `ESD_TICK_US)
`define ESD_ESR_DELAY_IPO 2

// ************************************************************
// Stop states
// ************************************************************
`define ESD_ST_NONE 3'h0
`define ESD_ST_A 3'h1
`define ESD_ST_C 3'h2
`define ESD_ST_D 3'h3
`define ESD_ST_E 3'h4
`define ESD_ST_HOLD 3'h5

`endif

/* File: design/esd_timer.v */
`timescale 1ns/1ps
`default_nettype none

// Down counter stepping once per tick; loads on entry, clears on abort.
module esd_timer #(
  parameter W = 16
) (
  input wire clk,
  input wire nrst,
  input wire load,
  input wire clear,
  input wire tick,
  input wire [W-1:0] value,
  output reg expired
);
  reg [W-1:0] cnt_r;
  reg run_r;

  always @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      expired <= 1'b0;
    end else if (clear) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      cnt_r <= value;
      run_r <= 1'b1;
      expired <= 1'b0;
    end else if (run_r && tick) begin
      if (cnt_r == {W{1'b0}}) begin
        run_r <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

`default_nettype wire

/* File: design/esd_stop_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "esd_defs.vh"

// Summary of operation
// - Test stop runs pulse path, then inputs.
// - Channel one phase one done on rising edge.
// - Channel two signals done by status output.
// - Pulse-stop input low cancels drive pulses.
// - Monitors stay active; responses held pending.
// - External pulse stop asserts A/B status.
// - Current-limit low: ramp, timer, then standstill.
// - Current-limit stop asserts C status.
// - Pulse stop outranks current-limit stop.
// - Path low: brake, own timer, then standstill.
// - Path stop asserts D status.
// - Pulse and current-limit outrank path stop.
// - Lowest input: retraction if armed, path if not configured.
// - Misconfigured retraction: current limit within two cycles.
// - Each status output high while stop active.
// - Inputs decoded by fixed priority.
// - Feature acts only with its enable bits.
// - Any input change starts tolerance timer.
module esd_stop_decode #(
  parameter TW = 16,
  parameter TICK_CYC = `ESD_TICK_CYC,
  parameter IPO_CYC = 40
) (
  input wire clk,
  input wire nrst,
  input wire [`ESD_ADDR_W-1:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire stop_a_n,
  input wire stop_c_n,
  input wire stop_d_n,
  input wire stop_e_n,
  input wire pulses_cancelled_in,
  input wire monitor_violation,
  output reg pulse_cancel,
  output reg safe_braking_ramp,
  output reg brake_current_limit,
  output reg brake_path,
  output reg extended_stop_retract,
  output reg safe_operating_stop,
  output reg stop_ab_active,
  output reg stop_c_active,
  output reg stop_d_active,
  output reg stop_e_active,
  output reg pulses_cancelled_out,
  output reg shutdown_response,
  output reg tol_active
);

  // ************************************************************
  // Configuration registers
  // ************************************************************
  reg [15:0] enable_r;
  reg [TW-1:0] time_c_r;
  reg [TW-1:0] time_d_r;
  reg [TW-1:0] tol_r;
  reg test_sel_r;
  reg phase1_ok_r;
  reg pending_r;
  reg pc_q_r;
  reg [3:0] in_q_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [31:0] esr_cnt_r;
  reg esr_late_r;
  wire exp_c;
  wire exp_d;
  wire exp_tol;

  // The feature and stop E each need their own enable, plus the base monitor.
  wire feat_en = enable_r[`ESD_EN_EXT_BIT] & enable_r[`ESD_EN_BASE_BIT];
  wire e_en = feat_en & enable_r[`ESD_EN_E_BIT];
  wire esr_armed = enable_r[`ESD_EN_ESR_CFG_BIT] & enable_r[`ESD_EN_ESR_OK_BIT];
  wire esr_bad = enable_r[`ESD_EN_ESR_CFG_BIT] & ~enable_r[`ESD_EN_ESR_OK_BIT];
  wire [3:0] in_now = {stop_e_n, stop_d_n, stop_c_n, stop_a_n};

  always @(posedge clk) begin
    if (!nrst) begin
      enable_r <= `ESD_ENABLE_RST;
      time_c_r <= `ESD_TIME_RST;
      time_d_r <= `ESD_TIME_RST;
      tol_r <= `ESD_TOL_RST;
      test_sel_r <= 1'b0;
    end else if (wr) begin
      if (addr == `ESD_REG_ENABLE) begin
        enable_r <= wdata;
      end else if (addr == `ESD_REG_TIME_C) begin
        time_c_r <= wdata[TW-1:0];
      end else if (addr == `ESD_REG_TIME_D) begin
        time_d_r <= wdata[TW-1:0];
      end else if (addr == `ESD_REG_TOL) begin
        tol_r <= wdata[TW-1:0];
      end else if (addr == `ESD_REG_TEST) begin
        test_sel_r <= wdata[`ESD_TEST_SEL_BIT];
      end
    end
  end

  // ************************************************************
  // Time base
  // ************************************************************
  always @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // ************************************************************
  // Priority decode
  // ************************************************************
  // priority stop decode
  always @* begin
    state_nxt = `ESD_ST_NONE;
    if (feat_en) begin
      if (!stop_a_n) begin
        state_nxt = `ESD_ST_A;
      end else if (!stop_c_n) begin
        state_nxt = `ESD_ST_C;
      end else if (!stop_d_n) begin
        state_nxt = `ESD_ST_D;
      end else if (!stop_e_n && e_en) begin
        state_nxt = `ESD_ST_E;
      end
    end
    // A finished C or D braking settles into the hold state.
    if ((state_nxt == `ESD_ST_C && state_r == `ESD_ST_C && exp_c) ||
        (state_nxt == `ESD_ST_C && state_r == `ESD_ST_HOLD && !stop_c_n) ||
        (state_nxt == `ESD_ST_D && state_r == `ESD_ST_D && exp_d) ||
        (state_nxt == `ESD_ST_D && state_r == `ESD_ST_HOLD && stop_c_n)) begin
      state_nxt = `ESD_ST_HOLD;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state_r <= `ESD_ST_NONE;
      in_q_r <= 4'hf;
    end else begin
      state_r <= state_nxt;
      in_q_r <= in_now;
    end
  end

  // ************************************************************
  // Transition timers
  // ************************************************************
  // current limit timer
  esd_timer #(.W(TW)) u_timer_c (
    .clk(clk),
    .nrst(nrst),
    .load(state_nxt == `ESD_ST_C && state_r != `ESD_ST_C),
    .clear(state_nxt != `ESD_ST_C),
    .tick(tick_r),
    .value(time_c_r),
    .expired(exp_c)
  );

  esd_timer #(.W(TW)) u_timer_d (
    .clk(clk),
    .nrst(nrst),
    .load(state_nxt == `ESD_ST_D && state_r != `ESD_ST_D),
    .clear(state_nxt != `ESD_ST_D),
    .tick(tick_r),
    .value(time_d_r),
    .expired(exp_d)
  );

  esd_timer #(.W(TW)) u_timer_tol (
    .clk(clk),
    .nrst(nrst),
    .load(in_now != in_q_r),
    .clear(1'b0),
    .tick(tick_r),
    .value(tol_r),
    .expired(exp_tol)
  );

  // ************************************************************
  // Misconfigured retraction fallback
  // ************************************************************
  // Two interpolation cycles is the worst case; we use the full budget.
  // bounded fallback delay
  always @(posedge clk) begin
    if (!nrst) begin
      esr_cnt_r <= 32'h0000_0000;
      esr_late_r <= 1'b0;
    end else if (state_r != `ESD_ST_E || !esr_bad) begin
      esr_cnt_r <= 32'h0000_0000;
      esr_late_r <= 1'b0;
    // The flag lands one cycle before the registered brake output, so stop one count early.
    end else if (esr_cnt_r == `ESD_ESR_DELAY_IPO * IPO_CYC - 2) begin
      esr_late_r <= 1'b1;
    end else begin
      esr_cnt_r <= esr_cnt_r + 32'h0000_0001;
    end
  end

  // ************************************************************
  // Test stop and pending shutdown
  // ************************************************************
  // phase one tracking
  always @(posedge clk) begin
    if (!nrst) begin
      pc_q_r <= 1'b0;
      phase1_ok_r <= 1'b0;
    end else begin
      pc_q_r <= pulses_cancelled_in;
      if (test_sel_r && pulses_cancelled_in && !pc_q_r) begin
        phase1_ok_r <= 1'b1;
      end else if (wr && addr == `ESD_REG_TEST && wdata[`ESD_TEST_ACK_BIT]) begin
        phase1_ok_r <= 1'b0;
      end
    end
  end

  // Violations during a pulse stop cannot act; they wait for the release.
  // hold pending response
  always @(posedge clk) begin
    if (!nrst) begin
      pending_r <= 1'b0;
      shutdown_response <= 1'b0;
    end else begin
      if (state_nxt == `ESD_ST_A) begin
        pending_r <= pending_r | monitor_violation;
        shutdown_response <= 1'b0;
      end else begin
        pending_r <= 1'b0;
        shutdown_response <= pending_r | monitor_violation;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always @(posedge clk) begin
    if (!nrst) begin
      pulse_cancel <= 1'b0;
      safe_braking_ramp <= 1'b0;
      brake_current_limit <= 1'b0;
      brake_path <= 1'b0;
      extended_stop_retract <= 1'b0;
      safe_operating_stop <= 1'b0;
      stop_ab_active <= 1'b0;
      stop_c_active <= 1'b0;
      stop_d_active <= 1'b0;
      stop_e_active <= 1'b0;
      pulses_cancelled_out <= 1'b0;
      tol_active <= 1'b0;
    end else begin
      pulse_cancel <= (state_nxt == `ESD_ST_A) | test_sel_r;
      safe_braking_ramp <= (state_nxt == `ESD_ST_C);
      brake_current_limit <= (state_nxt == `ESD_ST_C) |
                             (state_nxt == `ESD_ST_E && esr_bad && esr_late_r);
      brake_path <= (state_nxt == `ESD_ST_D) |
                    (state_nxt == `ESD_ST_E && !esr_armed && !esr_bad);
      extended_stop_retract <= (state_nxt == `ESD_ST_E) && esr_armed;
      safe_operating_stop <= (state_nxt == `ESD_ST_HOLD);
      stop_ab_active <= (state_nxt == `ESD_ST_A);
      stop_c_active <= (state_nxt == `ESD_ST_C) ||
                       (state_nxt == `ESD_ST_HOLD && !stop_c_n);
      stop_d_active <= (state_nxt == `ESD_ST_D) ||
                       (state_nxt == `ESD_ST_HOLD && stop_c_n);
      stop_e_active <= (state_nxt == `ESD_ST_E);
      pulses_cancelled_out <= test_sel_r & pulses_cancelled_in;
      tol_active <= (in_now != in_q_r) | (tol_active & ~exp_tol);
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always @(posedge clk) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (addr == `ESD_REG_ENABLE) begin
        rdata <= enable_r;
      end else if (addr == `ESD_REG_TIME_C) begin
        rdata <= time_c_r;
      end else if (addr == `ESD_REG_TIME_D) begin
        rdata <= time_d_r;
      end else if (addr == `ESD_REG_TOL) begin
        rdata <= tol_r;
      end else if (addr == `ESD_REG_STATUS) begin
        rdata <= {9'h000, state_r, in_q_r};
      end else if (addr == `ESD_REG_TEST) begin
        rdata <= {14'h0000, phase1_ok_r, test_sel_r};
      end else if (addr == `ESD_REG_PENDING) begin
        rdata <= {15'h0000, pending_r};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

/* File: bench/esd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ******************
// Stop decode checks
// ******************
module esd_chk (
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire stop_a_n,
  input wire stop_c_n,
  input wire stop_d_n,
  input wire stop_e_n,
  input wire pulses_cancelled_in,
  input wire pulse_cancel,
  input wire safe_braking_ramp,
  input wire safe_operating_stop,
  input wire stop_ab_active,
  input wire stop_c_active,
  input wire stop_d_active,
  input wire stop_e_active,
  input wire pulses_cancelled_out,
  input wire tol_active
);
  reg [15:0] en_r;
  wire ok = en_r[0] & en_r[6];
  wire [3:0] in_n = {stop_e_n, stop_d_n, stop_c_n, stop_a_n};
  wire [3:0] act = {stop_ab_active, stop_c_active, stop_d_active, stop_e_active};
  // The enable word is mirrored from the port, since the checker cannot look inside.
  always @(posedge clk) begin
    if (!nrst) begin
      en_r <= 16'h0000;
    end else if (wr && addr == 4'h0) begin
      en_r <= wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_a;
    ok && !stop_a_n |=> act == 4'h8 && pulse_cancel;
  endproperty
  a_a: assert property (p_a) else $error("a decode");
  property p_c;
    ok && in_n[1:0] == 2'b01 |=> act == 4'h4;
  endproperty
  a_c: assert property (p_c) else $error("c decode");
  property p_d;
    ok && in_n[2:0] == 3'b011 |=> act == 4'h2;
  endproperty
  a_d: assert property (p_d) else $error("d decode");
  property p_idle;
    ok && &in_n |=> act[2:0] == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle decode");
  property p_off;
    !ok |=> act[2:0] == 3'h0;
  endproperty
  a_off: assert property (p_off) else $error("acts while disabled");
  property p_ramp;
    stop_c_active && !safe_operating_stop |-> safe_braking_ramp;
  endproperty
  a_ramp: assert property (p_ramp) else $error("no ramp");
  property p_tol;
    ok && !$stable(in_n) |=> tol_active;
  endproperty
  a_tol: assert property (p_tol) else $error("no tolerance");
  property p_pco;
    !pulses_cancelled_in |=> !pulses_cancelled_out;
  endproperty
  a_pco: assert property (p_pco) else $error("false done");
endmodule
bind esd_stop_decode esd_chk u_chk (.*);
`default_nettype wire

/* File: bench/esd_far.sv */
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Sensors and controller
// ***********************
module esd_far (
  input wire clk,
  input wire [3:0] sel,
  input wire slow,
  input wire pulse_cancel,
  output reg [3:0] stop_n,
  output reg pc_in
);
  reg [3:0] d1_r;
  reg [2:0] fb_r;
  initial begin
    stop_n = 4'hf;
    pc_in = 1'b0;
    d1_r = 4'hf;
    fb_r = 3'h0;
  end
  always @(posedge clk) begin
    d1_r <= ~sel;
    stop_n <= slow ? d1_r : ~sel;
  end
  // pulse cancel feedback.
  // Feedback needs a cancel that stood three cycles, as a relay would.
  always @(posedge clk) begin
    fb_r <= {fb_r[1:0], pulse_cancel};
    pc_in <= pulse_cancel & fb_r[2];
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// *****************
// Stop decode bench
// *****************
module tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg monitor_violation = 1'b0;
  reg [3:0] sel = 4'h0;
  reg slow = 1'b0;
  reg [15:0] rv;
  wire [15:0] rdata;
  wire stop_a_n, stop_c_n, stop_d_n, stop_e_n, pulses_cancelled_in, pulse_cancel;
  wire safe_braking_ramp, brake_current_limit, brake_path, extended_stop_retract;
  wire safe_operating_stop, stop_ab_active, stop_c_active, stop_d_active, stop_e_active;
  wire pulses_cancelled_out, shutdown_response, tol_active;
  wire [3:0] st = {stop_ab_active, stop_c_active, stop_d_active, stop_e_active};
  wire [2:0] mon = {shutdown_response, brake_current_limit, safe_operating_stop};
  integer mismatches = 0;
  integer checks_done = 0;
  integer n;
  integer i;
  esd_stop_decode #(.TICK_CYC(4), .IPO_CYC(2)) uut (.*);
  esd_far far (.clk(clk), .sel(sel), .slow(slow), .pulse_cancel(pulse_cancel),
    .stop_n({stop_e_n, stop_d_n, stop_c_n, stop_a_n}), .pc_in(pulses_cancelled_in));
  always #25 clk = ~clk;
  task chk(input [127:0] what, input [15:0] e, input [15:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("Error %0s expected %h seen %h", what, e, g);
    end
  endtask
  task chk1(input [127:0] what, input e, input g);
    chk(what, {15'h0000, e}, {15'h0000, g});
  endtask
  task wreg(input [3:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task drive(input [3:0] v, input integer k);
    @(posedge clk);
    sel <= v;
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task waitb(input integer k, input integer lim);
    n = 0;
    while (mon[k] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask
  task t_regs;
    rreg(4'h0);
    chk("enable", 16'h0000, rv);
    rreg(4'h1);
    chk("time c", 16'h0064, rv);
    rreg(4'h2);
    chk("time d", 16'h0064, rv);
    rreg(4'h3);
    chk("tolerance", 16'h000a, rv);
    rreg(4'hf);
    chk("unmapped", 16'h0000, rv);
    drive(4'hf, 3);
    chk("disabled", 16'h0000, {12'h000, st});
    $display("done regs");
  endtask
  task t_prio;
    wreg(4'h0, 16'h0051);
    for (i = 0; i < 5; i = i + 1) begin
      slow <= i[0];
      drive(4'hf << i, 5);
      chk("priority", {12'h000, 4'h8 >> i}, {12'h000, st});
      chk1("pulse cancel", i == 0, pulse_cancel);
    end
    $display("done priority");
  endtask
  task t_sos(input [3:0] ra, input [3:0] v, input [3:0] es, input [3:0] hi, input [3:0] eh);
    wreg(ra, 16'h0002);
    drive(v, 3);
    chk("stop entry", {12'h000, es}, {12'h000, st});
    waitb(0, 40);
    chk1("standstill time", 1'b1, n >= 5 && n <= 13);
    chk("held status", {12'h000, es}, {12'h000, st});
    drive(hi, 3);
    chk("interrupt", {12'h000, eh}, {12'h000, st});
    drive(4'h0, 3);
    chk("released", 16'h0000, {12'h000, st});
    $display("done standstill");
  endtask
  task t_esr;
    wreg(4'h0, 16'h0151);
    drive(4'h8, 0);
    waitb(1, 20);
    chk1("late brake", 1'b1, n == 6);
    chk1("no retract", 1'b0, extended_stop_retract);
    drive(4'h0, 3);
    wreg(4'h0, 16'h0351);
    drive(4'h8, 3);
    chk1("retract", 1'b1, extended_stop_retract);
    drive(4'h0, 3);
    $display("done retract");
  endtask
  task t_test;
    wreg(4'h5, 16'h0001);
    drive(4'h0, 1);
    chk1("test cancel", 1'b1, pulse_cancel);
    drive(4'h0, 6);
    rreg(4'h5);
    chk("test done", 16'h0002, rv & 16'h0002);
    chk1("drive done", 1'b1, pulses_cancelled_out);
    wreg(4'h5, 16'h0002);
    rreg(4'h5);
    chk("test cleared", 16'h0000, rv & 16'h0002);
    $display("done test stop");
  endtask
  task t_pend;
    drive(4'h1, 3);
    @(posedge clk);
    monitor_violation <= 1'b1;
    @(posedge clk);
    monitor_violation <= 1'b0;
    drive(4'h1, 2);
    chk1("held response", 1'b0, shutdown_response);
    drive(4'h0, 0);
    waitb(2, 10);
    chk1("late response", 1'b1, n < 10);
    $display("done pending");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_prio;
    t_sos(4'h1, 4'h2, 4'h4, 4'h3, 4'h8);
    t_sos(4'h2, 4'h4, 4'h2, 4'h6, 4'h4);
    t_esr;
    t_test;
    t_pend;
    tally_and_finish;
  end
  // The run needs some 170 cycles, so 2000 cycles means a hang.
  initial begin
    #100000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
endmodule
`default_nettype wire
